// ---- core/ident_capture.sv ----
// Holds the attached-phy fields of the last IDENTIFY frame for one phy.
`timescale 1ns/1ps
`include "sas_phy_desc_defs.svh"

module ident_capture
	import sas_phy_desc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_frame_done,
	input wire ident_s i_frame,
	output ident_s o_held,
	output logic o_changed
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		ident_s held;
		logic changed;
	} cap_state_s;

	cap_state_s st_q;
	cap_state_s st_d;

	// Every field is loaded in the same edge, so a reader never sees a
	// mix of an old and a new frame.
	always_comb begin
		st_d = st_q;
		st_d.changed = 1'b0;
		if (i_frame_done) begin
			st_d.held = i_frame;
			st_d.changed = (i_frame != st_q.held);
		end
	end

	// Register the state; nothing is known about the neighbour at reset.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_held = st_q.held;
	assign o_changed = st_q.changed;

endmodule : ident_capture

// ---- core/sas_phy_desc_bank.sv ----
// Attached-phy and link-rate part of the two per-port phy descriptors.
`timescale 1ns/1ps
`include "sas_phy_desc_defs.svh"

module sas_phy_desc_bank
	import sas_phy_desc_pkg::*;
#(
	parameter logic [63:0] PORT_ADDR0 = 64'h5000_0000_0000_0001,
	parameter logic [63:0] PORT_ADDR1 = 64'h5000_0000_0000_0002,
	parameter logic [7:0] PHY_ID0 = 8'h00,
	parameter logic [7:0] PHY_ID1 = 8'h01,
	parameter logic [3:0] HW_MIN_RATE = 4'h8,
	parameter logic [3:0] HW_MAX_RATE = 4'hb
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [`NUM_PHYS-1:0] i_frame_done,
	input wire ident_s i_frame [`NUM_PHYS],
	input wire rd_req_s i_rd,
	input wire wr_req_s i_wr,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_wr_err,
	output logic [7:0] o_gen_code,
	output logic [`NUM_PHYS*4-1:0] o_prog_min,
	output logic [`NUM_PHYS*4-1:0] o_prog_max
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// Distinct identifiers and a sane hardware range are needed for the
	// descriptors to mean anything.
	if (PHY_ID0 == PHY_ID1) begin : g_bad_id
		$error("Both phys were given the same identifier.");
	end
	if (HW_MIN_RATE > HW_MAX_RATE) begin : g_bad_rate
		$error("Hardware minimum rate lies above the maximum.");
	end

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Pack the capability byte of an attached phy.
	function automatic logic [7:0] cap_byte(input ident_s f);
		logic [7:0] b;
		b = '0;
		b[7] = f.persistent;
		b[6:5] = f.power_cap;
		b[4] = f.slumber;
		b[3] = f.partial;
		b[2] = f.zpsds_persistent;
		b[1] = f.req_inside_zpsds;
		b[0] = f.break_reply;
		return b;
	endfunction : cap_byte

	// Pick one byte of a 64-bit address, most significant byte first.
	function automatic logic [7:0] addr_byte(input logic [63:0] a,
		input logic [2:0] idx);
		logic [2:0] sh;
		sh = 3'd7 - idx;
		return a[{sh, 3'b000} +: 8];
	endfunction : addr_byte

	// Tell whether an offset is the given rate byte of the descriptor.
	function automatic logic is_ofs(input logic [5:0] ofs,
		input logic [5:0] want);
		return ofs == want;
	endfunction : is_ofs

	// Next value of the generation counter, skipping the unknown code.
	function automatic logic [7:0] gen_next(input logic [7:0] g);
		logic [7:0] n;
		n = g + 8'h01;
		if (g == `GEN_MAX) begin
			n = `GEN_FIRST;
		end
		return n;
	endfunction : gen_next

	// ------------------------------------------------------------------
	// Capture slices
	// ------------------------------------------------------------------
	ident_s held [`NUM_PHYS];
	logic [`NUM_PHYS-1:0] frame_changed;

	for (genvar p = 0; p < `NUM_PHYS; p++) begin : g_phy
		ident_capture u_cap (
			.i_ref_clk(i_ref_clk),
			.i_resetn(i_resetn),
			.i_frame_done(i_frame_done[p]),
			.i_frame(i_frame[p]),
			.o_held(held[p]),
			.o_changed(frame_changed[p])
		);
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rd_data;
		logic rd_valid;
		logic wr_err;
		logic [7:0] gen;
		logic [`NUM_PHYS-1:0][3:0] prog_min;
		logic [`NUM_PHYS-1:0][3:0] prog_max;
	} bank_state_s;

	bank_state_s st_q;
	bank_state_s st_d;

	// ------------------------------------------------------------------
	// Per-phy constants
	// ------------------------------------------------------------------
	logic [63:0] own_addr [`NUM_PHYS];
	logic [7:0] own_id [`NUM_PHYS];

	assign own_id[0] = PHY_ID0;
	assign own_id[1] = PHY_ID1;
	assign own_addr[0] = PORT_ADDR0;
	assign own_addr[1] = PORT_ADDR1;

	// ------------------------------------------------------------------
	// Read selection
	// ------------------------------------------------------------------
	logic [7:0] rd_byte;
	ident_s rd_frame;
	logic [5:0] rel;

	// Combinational byte mux; anything not named below is reserved or
	// vendor-specific and reads zero.
	always_comb begin
		rd_byte = '0;
		rd_frame = held[i_rd.phy];
		rel = '0;
		if (i_rd.ofs == `PHY_ID_OFS) begin
			rd_byte = own_id[i_rd.phy];
		end else if (i_rd.ofs == `ATT_TYPE_OFS) begin
			rd_byte[6:4] = rd_frame.dev_type;
			rd_byte[3:0] = rd_frame.reason;
		end else if (i_rd.ofs >= `OWN_ADDR_OFS &&
			i_rd.ofs <= `OWN_ADDR_END) begin
			rel = i_rd.ofs - `OWN_ADDR_OFS;
			rd_byte = addr_byte(own_addr[i_rd.phy], rel[2:0]);
		end else if (i_rd.ofs >= `ATT_ADDR_OFS &&
			i_rd.ofs <= `ATT_ADDR_END) begin
			rel = i_rd.ofs - `ATT_ADDR_OFS;
			rd_byte = addr_byte(rd_frame.sas_addr, rel[2:0]);
		end else if (i_rd.ofs == `ATT_PHY_OFS) begin
			rd_byte = rd_frame.phy_id;
		end else if (i_rd.ofs == `ATT_CAP_OFS) begin
			rd_byte = cap_byte(rd_frame);
		end else if (is_ofs(i_rd.ofs, `MIN_RATE_OFS)) begin
			rd_byte[`RATE_PROG_MSB:`RATE_PROG_LSB] =
				st_q.prog_min[i_rd.phy];
			rd_byte[3:0] = HW_MIN_RATE;
		end else if (is_ofs(i_rd.ofs, `MAX_RATE_OFS)) begin
			rd_byte[`RATE_PROG_MSB:`RATE_PROG_LSB] =
				st_q.prog_max[i_rd.phy];
			rd_byte[3:0] = HW_MAX_RATE;
		end else begin
			rd_byte = '0;
		end
	end

	// ------------------------------------------------------------------
	// Write decoding
	// ------------------------------------------------------------------
	logic [3:0] wr_nib;
	logic wr_min;
	logic wr_max;
	logic wr_bad;
	logic wr_moved;

	// Only the programmed nibbles take writes; the hardware nibbles are
	// fixed and other bytes ignore data. A bound that would leave no
	// usable rate, or fall outside the hardware range, is refused whole.
	always_comb begin
		wr_nib = i_wr.data[`RATE_PROG_MSB:`RATE_PROG_LSB];
		wr_min = i_wr.en && is_ofs(i_wr.ofs, `MIN_RATE_OFS);
		wr_max = i_wr.en && is_ofs(i_wr.ofs, `MAX_RATE_OFS);
		wr_bad = 1'b0;
		wr_moved = 1'b0;
		if (wr_min) begin
			wr_bad = (wr_nib < HW_MIN_RATE) ||
				(wr_nib > st_q.prog_max[i_wr.phy]);
			wr_moved = (wr_nib != st_q.prog_min[i_wr.phy]);
		end else if (wr_max) begin
			wr_bad = (wr_nib > HW_MAX_RATE) ||
				(wr_nib < st_q.prog_min[i_wr.phy]);
			wr_moved = (wr_nib != st_q.prog_max[i_wr.phy]);
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	logic any_change;

	// A read answers one cycle later; a write takes effect at the same
	// edge, so a read in the write cycle still returns the old value.
	always_comb begin
		st_d = st_q;
		st_d.rd_valid = i_rd.en;
		st_d.wr_err = 1'b0;
		any_change = 1'b0;
		if (i_rd.en) begin
			st_d.rd_data = rd_byte;
		end
		if (wr_min || wr_max) begin
			if (wr_bad) begin
				st_d.wr_err = 1'b1;
			end else if (wr_min) begin
				st_d.prog_min[i_wr.phy] = wr_nib;
				any_change = wr_moved;
			end else begin
				st_d.prog_max[i_wr.phy] = wr_nib;
				any_change = wr_moved;
			end
		end
		// Several changes in one cycle count once; the page is only
		// ever read between cycles, so one step is enough.
		if (|frame_changed) begin
			any_change = 1'b1;
		end
		if (any_change) begin
			st_d.gen = gen_next(st_q.gen);
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Programmed bounds start at the full hardware range; the counter
	// starts at the unknown code.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			st_q.rd_data <= '0;
			st_q.rd_valid <= 1'b0;
			st_q.wr_err <= 1'b0;
			st_q.gen <= `GEN_UNKNOWN;
			st_q.prog_min <= {`NUM_PHYS{HW_MIN_RATE}};
			st_q.prog_max <= {`NUM_PHYS{HW_MAX_RATE}};
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// All data outputs come straight from the state register.
	assign o_rd_data = st_q.rd_data;
	assign o_rd_valid = st_q.rd_valid;
	assign o_wr_err = st_q.wr_err;
	assign o_gen_code = st_q.gen;
	// The link layer steers speed negotiation from these bounds.
	assign o_prog_min = st_q.prog_min;
	assign o_prog_max = st_q.prog_max;

endmodule : sas_phy_desc_bank

// ---- core/sas_phy_desc_defs.svh ----
// Offsets, field positions, reset values and limits of the phy descriptor.
`ifndef SAS_PHY_DESC_DEFS_SVH
`define SAS_PHY_DESC_DEFS_SVH

// ----------------------------------------------------------------------
// Descriptor geometry
// ----------------------------------------------------------------------
`define NUM_PHYS 2
`define DESC_LEN 6'd48
`define PHY_ID_OFS 6'h01
`define ATT_TYPE_OFS 6'h04
`define OWN_ADDR_OFS 6'h08
`define OWN_ADDR_END 6'h0f
`define ATT_ADDR_OFS 6'h10
`define ATT_ADDR_END 6'h17
`define ATT_PHY_OFS 6'h18
`define ATT_CAP_OFS 6'h19
`define MIN_RATE_OFS 6'h20
`define MAX_RATE_OFS 6'h21

// ----------------------------------------------------------------------
// Field positions inside the rate bytes
// ----------------------------------------------------------------------
`define RATE_PROG_MSB 7
`define RATE_PROG_LSB 4

// ----------------------------------------------------------------------
// Generation counter values
// ----------------------------------------------------------------------
`define GEN_UNKNOWN 8'h00
`define GEN_FIRST 8'h01
`define GEN_MAX 8'hff

`endif

// ---- core/sas_phy_desc_pkg.sv ----
// Types shared by the phy descriptor bank and its capture slices.
package sas_phy_desc_pkg;

	// Fields of one received IDENTIFY address frame.
	typedef struct packed {
		logic [63:0] sas_addr;
		logic [7:0] phy_id;
		logic [2:0] dev_type;
		logic [3:0] reason;
		logic persistent;
		logic [1:0] power_cap;
		logic slumber;
		logic partial;
		logic zpsds_persistent;
		logic req_inside_zpsds;
		logic break_reply;
	} ident_s;

	// Byte read request from the mode page engine.
	typedef struct packed {
		logic en;
		logic phy;
		logic [5:0] ofs;
	} rd_req_s;

	// Byte write request from the mode page engine.
	typedef struct packed {
		logic en;
		logic phy;
		logic [5:0] ofs;
		logic [7:0] data;
	} wr_req_s;

endpackage : sas_phy_desc_pkg

// ---- verif/sas_attached_phy_model.sv ----
// Attached phy model that delivers IDENTIFY frames to the bank.
`timescale 1ns/1ps
module sas_attached_phy_model
	import sas_phy_desc_pkg::*;
(
	input wire logic i_ref_clk,
	output logic [1:0] o_frame_done,
	output ident_s o_frame [2]
);
	// Fields mean nothing off the pulse, so they are scrambled there.
	initial begin
		o_frame_done = 2'b00;
		o_frame[0] = '0;
		o_frame[1] = '1;
	end

	// One frame, one pulse, driven off the sampling edge.
	task automatic send(input int p, input ident_s f);
		@(negedge i_ref_clk);
		o_frame_done[p] = 1'b1;
		o_frame[p] = f;
		@(negedge i_ref_clk);
		o_frame_done[p] = 1'b0;
		o_frame[p] = ~f;
	endtask : send
endmodule : sas_attached_phy_model

// ---- verif/sas_phy_desc_checker_assertions.sv ----
// Port checker for the phy descriptor bank.
`timescale 1ns/1ps
module sas_phy_desc_checker
	import sas_phy_desc_pkg::*;
#(
	parameter logic [3:0] HW_MIN_RATE = 4'h8,
	parameter logic [3:0] HW_MAX_RATE = 4'hb
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire rd_req_s i_rd,
	input wire wr_req_s i_wr,
	input wire logic [1:0] i_frame_done,
	input wire logic o_rd_valid,
	input wire logic o_wr_err,
	input wire logic [7:0] o_gen_code,
	input wire logic [7:0] o_prog_min,
	input wire logic [7:0] o_prog_max
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	// Every read gets exactly one answer, one cycle later.
	chk_rd_answer: assert property (i_rd.en |=> o_rd_valid)
		else $error("read answer missing");
	chk_rd_spurious: assert property (o_rd_valid |-> $past(i_rd.en))
		else $error("read answer without request");
	// The counter starts unknown and never returns there.
	chk_gen_start: assert property ($rose(i_resetn) |-> o_gen_code == 8'h00)
		else $error("generation code not zero after reset");
	chk_gen_step: assert property ($changed(o_gen_code) |->
		o_gen_code == (($past(o_gen_code) == 8'hff) ? 8'h01 :
		$past(o_gen_code) + 8'h01))
		else $error("generation code step wrong");
	// A write moves the counter one edge later, a frame two edges later.
	chk_gen_quiet: assert property ($changed(o_gen_code) |->
		$past(i_wr.en) || $past(i_frame_done, 2) != 2'b00)
		else $error("generation code moved without a cause");
	// Programmed bounds stay inside the hardware range.
	chk_min_bounds: assert property (o_prog_min[3:0] >= HW_MIN_RATE &&
		o_prog_min[7:4] >= HW_MIN_RATE && o_prog_min[3:0] <= o_prog_max[3:0]
		&& o_prog_min[7:4] <= o_prog_max[7:4])
		else $error("programmed minimum out of range");
	chk_max_bounds: assert property (o_prog_max[3:0] <= HW_MAX_RATE &&
		o_prog_max[7:4] <= HW_MAX_RATE)
		else $error("programmed maximum out of range");
	// Bounds move only by a write; a refused write moves nothing.
	chk_rate_hold: assert property (!i_wr.en |=>
		$stable(o_prog_min) && $stable(o_prog_max))
		else $error("rate moved without a write");
	chk_err_cause: assert property (o_wr_err |-> $past(i_wr.en) &&
		$past(i_wr.ofs[5:1]) == 5'h10 && $stable(o_prog_min) &&
		$stable(o_prog_max))
		else $error("write error without refused rate write");
endmodule : sas_phy_desc_checker

bind sas_phy_desc_bank sas_phy_desc_checker #(
	.HW_MIN_RATE(HW_MIN_RATE),
	.HW_MAX_RATE(HW_MAX_RATE)
) u_chk (
	.i_ref_clk(i_ref_clk),
	.i_resetn(i_resetn),
	.i_rd(i_rd),
	.i_wr(i_wr),
	.i_frame_done(i_frame_done),
	.o_rd_valid(o_rd_valid),
	.o_wr_err(o_wr_err),
	.o_gen_code(o_gen_code),
	.o_prog_min(o_prog_min),
	.o_prog_max(o_prog_max)
);

// ---- verif/tb_sas_phy_desc_bank.sv ----
// Self-checking bench for the phy descriptor bank.
`timescale 1ns/1ps
module tb_sas_phy_desc_bank
	import sas_phy_desc_pkg::*;
;
	localparam logic [63:0] PA0 = 64'h5000_0000_0000_00a1;
	localparam logic [63:0] PA1 = 64'h5000_0000_0000_00b2;
	localparam logic [7:0] PID0 = 8'h03;
	localparam logic [7:0] PID1 = 8'h07;
	localparam logic [3:0] HMIN = 4'h8;
	localparam logic [3:0] HMAX = 4'hb;
	localparam int LIMIT = 5000;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] done;
	ident_s frame [2];
	rd_req_s rd = '0;
	wr_req_s wr = '0;
	logic [7:0] rdata, gen, pmin_o, pmax_o;
	logic vld, werr;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	int pmin [2] = '{HMIN, HMIN};
	int pmax [2] = '{HMAX, HMAX};
	int gen_m = 0;
	int p, e, seed;
	ident_s held [2] = '{'0, '0};
	logic [95:0] r;
	int wt [12] = '{'h02070, 'h02090, 'h021c0, 'h02180, 'h021a0, 'h020b0,
		'h02090, 'h019ff, 'h120b0, 'h12180, 'h121b0, 'h12080};

	always #50 clk = ~clk;

	sas_phy_desc_bank #(.PORT_ADDR0(PA0), .PORT_ADDR1(PA1), .PHY_ID0(PID0),
		.PHY_ID1(PID1), .HW_MIN_RATE(HMIN), .HW_MAX_RATE(HMAX)) dut (
		.i_ref_clk(clk), .i_resetn(rstn), .i_frame_done(done),
		.i_frame(frame), .i_rd(rd), .i_wr(wr), .o_rd_data(rdata),
		.o_rd_valid(vld), .o_wr_err(werr), .o_gen_code(gen),
		.o_prog_min(pmin_o), .o_prog_max(pmax_o));
	sas_attached_phy_model phy_model (.i_ref_clk(clk), .o_frame_done(done),
		.o_frame(frame));

	task automatic check(input string s, input logic [7:0] x, logic [7:0] g);
		checks++;
		if (g !== x) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", s, x, g);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict

	// Expected byte of a descriptor, built from the reference state.
	function automatic logic [7:0] exp_byte(input int q, input int o);
		ident_s h;
		logic [63:0] a;
		h = held[q];
		a = (o < 16) ? (q ? PA1 : PA0) : h.sas_addr;
		case (o) inside
			1: return q ? PID1 : PID0;
			4: return {1'b0, h.dev_type, h.reason};
			[8:23]: return a[8*(7-o%8) +: 8];
			24: return h.phy_id;
			25: return h[6:0] | {h.persistent, 7'h00};
			32: return {pmin[q][3:0], HMIN};
			33: return {pmax[q][3:0], HMAX};
			default: return 8'h00;
		endcase
	endfunction : exp_byte

	// The counter skips zero on wrap, so zero keeps meaning unknown.
	function automatic void step();
		gen_m = (gen_m == 255) ? 1 : gen_m + 1;
	endfunction : step

	task automatic rd_chk(input int q, input int o);
		string nm;
		nm = $sformatf("phy %0d byte %0d", q, o);
		@(negedge clk);
		rd = {1'b1, q[0], o[5:0]};
		@(negedge clk);
		rd.en = 1'b0;
		check("rd_valid", 8'h01, {7'h00, vld});
		check(nm, exp_byte(q, o), rdata);
	endtask : rd_chk

	task automatic wr_chk(input int q, input int o, input logic [7:0] d);
		int v;
		logic bad;
		v = d[7:4];
		bad = (o == 32) ? (v < HMIN || v > pmax[q]) :
			(o == 33) ? (v > HMAX || v < pmin[q]) : 1'b0;
		@(negedge clk);
		wr = {1'b1, q[0], o[5:0], d};
		@(negedge clk);
		wr.en = 1'b0;
		if (!bad && ((o == 32 && pmin[q] != v) || (o == 33 && pmax[q] != v)))
			step();
		if (!bad && o == 32)
			pmin[q] = v;
		if (!bad && o == 33)
			pmax[q] = v;
		check("wr_err", {7'h00, bad}, {7'h00, werr});
		check("prog_min", {pmin[1][3:0], pmin[0][3:0]}, pmin_o);
		check("prog_max", {pmax[1][3:0], pmax[0][3:0]}, pmax_o);
		check("gen_code", gen_m[7:0], gen);
	endtask : wr_chk

	task automatic frm(input int q, input ident_s f);
		phy_model.send(q, f);
		if (f != held[q])
			step();
		held[q] = f;
		@(negedge clk);
		check("gen_code", gen_m[7:0], gen);
	endtask : frm

	// Hang guard: a run far beyond its expected length is a failure.
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		seed = $urandom(32'h1ffc7050);
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		check("gen_code", 8'h00, gen);
		for (int q = 0; q < 2; q++)
			for (int o = 0; o < 64; o++)
				rd_chk(q, o);
		// Random frames, some repeated, each followed by a readback of the attached-phy bytes.
		for (int i = 0; i < 24; i++) begin
			r = {$urandom(), $urandom(), $urandom()};
			p = $urandom_range(1);
			frm(p, (i % 5 == 4) ? held[p] : r[86:0]);
			rd_chk(p, 4);
			for (int o = 16; o < 26; o++)
				rd_chk(p, o);
			rd_chk(1 - p, 16);
		end
		foreach (wt[i]) begin
			e = wt[i];
			wr_chk(e >> 16, (e >> 8) & 'hff, e[7:0]);
		end
		for (int i = 0; i < 40; i++)
			wr_chk($urandom_range(1), 32 + $urandom_range(1), 8'($urandom()));
		wr_chk(0, 33, 8'hb0);
		for (int i = 0; i < 270; i++)
			wr_chk(0, 32, (i % 2) ? 8'h80 : 8'h90);
		rd_chk(0, 32);
		give_verdict();
	end
endmodule : tb_sas_phy_desc_bank
